// ---- rtl/aowg_defs.svh ----
// Purpose: constants of the waveform generation control block
// Assumes: 32-bit register port, byte offsets, 200 MHz core clock
// Notes:   definitions only
`ifndef AOWG_DEFS_SVH
`define AOWG_DEFS_SVH

// register byte offsets
`define AOWG_OFF_CTRL      8'h00
`define AOWG_OFF_CONFIG    8'h04
`define AOWG_OFF_COUNT     8'h08
`define AOWG_OFF_RATE      8'h0C
`define AOWG_OFF_SWDATA    8'h10
`define AOWG_OFF_STATUS    8'h14

// control bits (write only, self clearing)
`define AOWG_CTRL_START    0
`define AOWG_CTRL_STOP     1
`define AOWG_CTRL_FLUSH    2

// configuration bits
`define AOWG_CFG_HWTIMED   0
`define AOWG_CFG_CONT      1
`define AOWG_CFG_TRIG_EN   2
`define AOWG_CFG_TRIG_SEL  3
`define AOWG_CFG_TRIG_FALL 4
`define AOWG_CFG_WIDTH     5

// status bits
`define AOWG_STS_RUN       0
`define AOWG_STS_ARMED     1
`define AOWG_STS_UNDERFLOW 2
`define AOWG_STS_DONE      3
`define AOWG_STS_LEVEL_LSB 8

// reset values
`define AOWG_ZERO_CODE     16'h8000
`define AOWG_COUNT_RESET   32'h0000_0001
`define AOWG_RATE_RESET    32'h0000_00C8

// output sample queue geometry
`define AOWG_QUEUE_DEPTH   16
`define AOWG_QUEUE_AW      4

`endif

// ---- rtl/aowg_pkg.sv ----
// Purpose: types of the waveform generation control block
// Assumes: constants come from aowg_defs.svh
// Notes:   one sample carries a code for each of the two channels
package aowg_pkg;

  // one update: both channel codes, offset binary
  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } aowg_sample_t;

  // generation sequencer
  typedef enum logic [1:0] {
    AOWG_IDLE = 2'b00,
    AOWG_WAIT = 2'b01,
    AOWG_RUN  = 2'b10
  } aowg_state_t;

endpackage

// ---- rtl/aowg_ctrl.sv ----
// Purpose: analog output generation control, queue to two DAC channels
// Assumes: one clock core_clk at 200 MHz, synchronous active-high reset
// Notes:   samples arrive on a valid/ready stream from the USB side
//
// Functional notes
// R1: two independent DAC channel code outputs
// R2: host streams sample blocks into the queue
// R3: pop one queued sample per DAC update
// R4: block sets update rate and start condition
// R5: hardware mode paced by internal sample clock
// R6: software mode updates DAC once per command
// R7: optional start waits for edge on chosen input
// R8: trigger edge polarity selectable rising or falling
// R9: finite mode stops after configured sample count
// R10: continuous mode runs until host stop command
// R11: both channels reset to zero-volt code
// R12: further trigger edges ignored while running
// R13: empty queue holds DAC and flags underflow
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "aowg_defs.svh"

module aowg_ctrl
  import aowg_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  // sample stream from the host side
  input  wire logic         in_valid,
  input  wire aowg_sample_t in_sample,
  output logic              in_ready,
  // trigger pins
  input  wire logic         trigger_input_a,
  input  wire logic         trigger_input_b,
  // DAC channels
  output logic      [15:0]  analog_out_zero,
  output logic      [15:0]  analog_out_one,
  output logic              dac_load,
  output logic              gen_active
);

  ////////////////////////////////////////////////////////////////////////
  // register decode

  // true when a strobe addresses a given offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [`AOWG_CFG_WIDTH-1:0] cfg;
  logic [31:0]                sample_target;
  logic [31:0]                rate_div;
  logic                       underflow;
  logic                       done;
  aowg_state_t                state;

  logic start_cmd;
  logic stop_cmd;
  logic flush_cmd;
  logic sw_cmd;
  logic sts_wr;

  assign start_cmd = reg_wr && hit(reg_addr, `AOWG_OFF_CTRL)
                     && reg_wdata[`AOWG_CTRL_START];
  assign stop_cmd  = reg_wr && hit(reg_addr, `AOWG_OFF_CTRL)
                     && reg_wdata[`AOWG_CTRL_STOP];
  assign flush_cmd = reg_wr && hit(reg_addr, `AOWG_OFF_CTRL)
                     && reg_wdata[`AOWG_CTRL_FLUSH];
  assign sw_cmd    = reg_wr && hit(reg_addr, `AOWG_OFF_SWDATA);
  assign sts_wr    = reg_wr && hit(reg_addr, `AOWG_OFF_STATUS);

  // configuration is only taken while idle so a run keeps its setup
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cfg           <= '0;
      sample_target <= `AOWG_COUNT_RESET;
      rate_div      <= `AOWG_RATE_RESET;
    end
    else if (reg_wr && state == AOWG_IDLE)
    begin
      if (hit(reg_addr, `AOWG_OFF_CONFIG))
        cfg <= reg_wdata[`AOWG_CFG_WIDTH-1:0];
      if (hit(reg_addr, `AOWG_OFF_COUNT))
        sample_target <= reg_wdata;
      if (hit(reg_addr, `AOWG_OFF_RATE))
        rate_div <= reg_wdata;
    end
  end

  logic cfg_hw;
  logic cfg_cont;
  logic cfg_trig_en;
  logic cfg_trig_sel;
  logic cfg_trig_fall;

  assign cfg_hw        = cfg[`AOWG_CFG_HWTIMED];
  assign cfg_cont      = cfg[`AOWG_CFG_CONT];
  assign cfg_trig_en   = cfg[`AOWG_CFG_TRIG_EN];
  assign cfg_trig_sel  = cfg[`AOWG_CFG_TRIG_SEL];
  assign cfg_trig_fall = cfg[`AOWG_CFG_TRIG_FALL];

  ////////////////////////////////////////////////////////////////////////
  // output sample queue

  aowg_sample_t             queue_mem [`AOWG_QUEUE_DEPTH];
  logic [`AOWG_QUEUE_AW-1:0] wr_ptr;
  logic [`AOWG_QUEUE_AW-1:0] rd_ptr;
  logic [`AOWG_QUEUE_AW:0]   level;
  logic [`AOWG_QUEUE_AW:0]   next_level;
  logic                      push;
  logic                      pop;
  logic                      q_empty;

  assign push    = in_valid && in_ready;                   // R2
  assign q_empty = (level == '0);
  assign next_level = flush_cmd && state == AOWG_IDLE ? '0 :
                      level + {{`AOWG_QUEUE_AW{1'b0}}, push}
                            - {{`AOWG_QUEUE_AW{1'b0}}, pop};

  // storage; the host side stalls on in_ready, so no word is lost
  always_ff @(posedge core_clk)
  begin
    if (push)
      queue_mem[wr_ptr] <= in_sample;
  end

  // pointers and fill level
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      level    <= '0;
      in_ready <= 1'b0;
    end
    else if (flush_cmd && state == AOWG_IDLE)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      level    <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;                           // R3
      level    <= next_level;
      in_ready <= next_level < (`AOWG_QUEUE_AW+1)'(`AOWG_QUEUE_DEPTH);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger inputs: two-stage synchronisers, then an edge history flop

  logic [1:0] trig_pin;
  logic [1:0] trig_s1;
  logic [1:0] trig_s2;
  logic [1:0] trig_prev;

  assign trig_pin = {trigger_input_b, trigger_input_a};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_trig_sync
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          trig_s1[i]   <= 1'b0;
          trig_s2[i]   <= 1'b0;
          trig_prev[i] <= 1'b0;
        end
        else
        begin
          trig_s1[i]   <= trig_pin[i];
          trig_s2[i]   <= trig_s1[i];
          trig_prev[i] <= trig_s2[i];
        end
      end
    end
  endgenerate

  logic trig_cur;
  logic trig_old;
  logic trig_hit;

  assign trig_cur = trig_s2[cfg_trig_sel];                 // R7
  assign trig_old = trig_prev[cfg_trig_sel];
  assign trig_hit = cfg_trig_fall ? (trig_old && !trig_cur)
                                  : (!trig_old && trig_cur); // R8

  ////////////////////////////////////////////////////////////////////////
  // sample clock: divider of core_clk, first tick right after start

  logic [31:0] rate_cnt;
  logic        tick;

  assign tick = (state == AOWG_RUN) && (rate_cnt == '0);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rate_cnt <= '0;
    else if (state != AOWG_RUN)
      rate_cnt <= '0;
    else if (tick)
      rate_cnt <= (rate_div == '0) ? '0 : rate_div - 1'b1; // R5
    else
      rate_cnt <= rate_cnt - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  logic [31:0] sent_cnt;
  logic        last_pop;

  assign pop      = tick && !q_empty;                      // R3
  assign last_pop = pop && !cfg_cont
                    && (sent_cnt + 32'h1 == sample_target);

  // stop has priority; edges outside the wait state are not looked at
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state <= AOWG_IDLE;
    else if (stop_cmd)
      state <= AOWG_IDLE;                                  // R10
    else
    begin
      case (state)
        AOWG_IDLE:
          if (start_cmd && cfg_hw)
            state <= cfg_trig_en ? AOWG_WAIT : AOWG_RUN;   // R4
        AOWG_WAIT:                                         // R12
          if (trig_hit)
            state <= AOWG_RUN;                             // R7
        AOWG_RUN:
          if (last_pop)
            state <= AOWG_IDLE;                            // R9
        default:
          state <= AOWG_IDLE;
      endcase
    end
  end

  // samples written in the current run
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      sent_cnt <= '0;
    else if (state == AOWG_IDLE)
      sent_cnt <= '0;
    else if (pop)
      sent_cnt <= sent_cnt + 32'h1;                        // R9
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the clearing cycle wins

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      underflow <= 1'b0;
    else if (tick && q_empty)
      underflow <= 1'b1;                                   // R13
    else if (sts_wr && reg_wdata[`AOWG_STS_UNDERFLOW])
      underflow <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      done <= 1'b0;
    else if (last_pop)
      done <= 1'b1;                                        // R9
    else if (sts_wr && reg_wdata[`AOWG_STS_DONE])
      done <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // DAC codes; an empty queue leaves the last code in place

  logic sw_update;

  // software commands only act while no timed run owns the DACs
  assign sw_update = sw_cmd && !cfg_hw && state == AOWG_IDLE;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      analog_out_zero <= `AOWG_ZERO_CODE;                  // R11
      analog_out_one  <= `AOWG_ZERO_CODE;                  // R11
    end
    else if (pop)
    begin
      analog_out_zero <= queue_mem[rd_ptr].ch0;            // R1
      analog_out_one  <= queue_mem[rd_ptr].ch1;            // R1
    end
    else if (sw_update)
    begin
      analog_out_zero <= reg_wdata[15:0];                  // R6
      analog_out_one  <= reg_wdata[31:16];                 // R6
    end
  end

  // load strobe: one pulse per update, none while starved
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      dac_load   <= 1'b0;
      gen_active <= 1'b0;
    end
    else
    begin
      dac_load   <= pop || sw_update;                      // R13
      // held through the cycle of the last pop, so a one-sample run
      // still shows activity beside its single load pulse
      gen_active <= (state == AOWG_RUN) && !stop_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data stand in the cycle after the strobe only

  logic [31:0] status_word;

  assign status_word = {16'h0000,
                        3'b000, level,
                        4'h0, done, underflow,
                        state == AOWG_WAIT,
                        state == AOWG_RUN};

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else if (hit(reg_addr, `AOWG_OFF_CONFIG))
      reg_rdata <= {{(32-`AOWG_CFG_WIDTH){1'b0}}, cfg};
    else if (hit(reg_addr, `AOWG_OFF_COUNT))
      reg_rdata <= sample_target;
    else if (hit(reg_addr, `AOWG_OFF_RATE))
      reg_rdata <= rate_div;
    else if (hit(reg_addr, `AOWG_OFF_SWDATA))
      reg_rdata <= {analog_out_one, analog_out_zero};
    else if (hit(reg_addr, `AOWG_OFF_STATUS))
      reg_rdata <= status_word;
    else
      reg_rdata <= '0;  // control and unmapped read as zero
  end

endmodule // aowg_ctrl

// ---- verif/aowg_ctrl_asserts.sv ----
// Purpose: port-level properties of the generation control block
// Assumes: config writes are only issued while the block is idle
// Notes:   sees the top module ports only, bound below
`timescale 1ns/1ps
`include "aowg_defs.svh"

module aowg_ctrl_chk
  import aowg_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // stream and outputs
  input wire logic        in_ready,
  input wire logic [15:0] analog_out_zero,
  input wire logic [15:0] analog_out_one,
  input wire logic        dac_load,
  input wire logic        gen_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic cfg_hw;
  // shadow of the pacing mode, needed to know when a code write is taken
  always_ff @(posedge core_clk)
    if (sys_rst)
      cfg_hw <= 1'b0;
    else if (reg_wr && reg_addr == `AOWG_OFF_CONFIG && !gen_active)
      cfg_hw <= reg_wdata[`AOWG_CFG_HWTIMED];

  ////////////////////////////////////////
  sequence s_sw_write;
    reg_wr && reg_addr == `AOWG_OFF_SWDATA && !cfg_hw && !gen_active;
  endsequence
  sequence s_stop_write;
    reg_wr && reg_addr == `AOWG_OFF_CTRL && reg_wdata[`AOWG_CTRL_STOP];
  endsequence

  a_zero_reset: assert property (
    $fell(sys_rst) |-> analog_out_zero == `AOWG_ZERO_CODE
      && analog_out_one == `AOWG_ZERO_CODE && !dac_load)
    else $error("codes not at zero volt after reset");
  a_ready_rise: assert property (
    $fell(sys_rst) |=> in_ready)
    else $error("queue not ready after reset");
  a_sw_update: assert property (
    s_sw_write |=> dac_load && analog_out_zero == $past(reg_wdata[15:0])
      && analog_out_one == $past(reg_wdata[31:16]))
    else $error("software code write not applied");
  a_load_cause: assert property (
    dac_load |-> gen_active || $past(gen_active)
      || ($past(reg_wr) && $past(reg_addr) == `AOWG_OFF_SWDATA))
    else $error("update pulse without a cause");
  a_codes_hold: assert property (
    ($changed(analog_out_zero) || $changed(analog_out_one))
      && !$past(sys_rst) |-> dac_load)
    else $error("codes changed without update pulse");
  a_stop_idle: assert property (
    s_stop_write |-> ##[1:2] !gen_active)
    else $error("stop did not end the run");
  a_unmapped_read: assert property (
    reg_rd && reg_addr > `AOWG_OFF_STATUS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_quiet: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_level_cap: assert property (
    reg_rd && reg_addr == `AOWG_OFF_STATUS |=> reg_rdata[12:8] <= 5'h10)
    else $error("queue level above depth");
endmodule // aowg_ctrl_chk

bind aowg_ctrl aowg_ctrl_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .in_ready(in_ready),
  .analog_out_zero(analog_out_zero), .analog_out_one(analog_out_one),
  .dac_load(dac_load), .gen_active(gen_active));

// ---- verif/aowg_host_model.sv ----
// Purpose: host side streaming sample words into the queue
// Assumes: words are pushed into q by the bench
// Notes:   gap adds idle cycles before each word to model a slow host
`timescale 1ns/1ps

module aowg_host_model
  import aowg_pkg::*;
(
  // clock and reset
  input wire logic     core_clk,
  input wire logic     sys_rst,
  // sample stream
  input wire logic     in_ready,
  output logic         in_valid,
  output aowg_sample_t in_sample
);
  aowg_sample_t q[$];
  int           gap = 0;

  // hold each word until taken; released data is inverted, not kept
  initial
  begin
    in_valid = 1'b0;
    in_sample = '0;
    forever
    begin
      @(posedge core_clk);
      if (!sys_rst && q.size() > 0)
      begin
        repeat (gap) @(posedge core_clk);
        in_valid <= 1'b1;
        in_sample <= q[0];
        do
          @(posedge core_clk);
        while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        in_sample <= ~q.pop_front();
      end
    end
  end
endmodule // aowg_host_model

// ---- verif/aowg_ctrl_tb.sv ----
// Purpose: self-checking bench of the generation control block
// Assumes: host model feeds the queue, bench owns registers and pins
// Notes:   each scenario checks its own results
`timescale 1ns/1ps
`include "aowg_defs.svh"

module aowg_ctrl_tb;
  import aowg_pkg::*;
  logic         core_clk, sys_rst, reg_wr, reg_rd, in_valid, in_ready;
  logic         dac_load, gen_active;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rdv;
  logic [15:0]  analog_out_zero, analog_out_one;
  logic [1:0]   trg;
  aowg_sample_t in_sample;
  int n_errors = 0, check_count = 0, n_loads = 0, n0;
  int cyc = 0, last_cyc = 0, last_gap = 0;

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  aowg_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_sample(in_sample), .in_ready(in_ready),
    .trigger_input_a(trg[0]), .trigger_input_b(trg[1]),
    .analog_out_zero(analog_out_zero), .analog_out_one(analog_out_one),
    .dac_load(dac_load), .gen_active(gen_active));
  aowg_host_model u_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .in_ready(in_ready), .in_valid(in_valid), .in_sample(in_sample));

  // count update pulses and the spacing of the last two
  always @(posedge core_clk)
  begin
    cyc++;
    if (dac_load === 1'b1)
    begin
      n_loads++;
      last_gap = cyc - last_cyc;
      last_cyc = cyc;
    end
  end

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic push(input int n);
    for (int k = 0; k < n; k++)
      u_host.q.push_back(32'hA0005000 + 32'h10001 * k);
  endtask
  task automatic pin(input logic [1:0] v);
    @(posedge core_clk);
    trg <= v;
    idle(12);
  endtask
  task automatic start_run(input int n);
    push(n);
    idle(2 * n + 6);
    n0 = n_loads;
    wr(`AOWG_OFF_CTRL, 32'h1);
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    chk("dac0", 32'h8000, {16'h0, analog_out_zero});
    chk("dac1", 32'h8000, {16'h0, analog_out_one});
    rd(`AOWG_OFF_COUNT);
    chk("count", 32'h1, rdv);
    rd(`AOWG_OFF_RATE);
    chk("rate", 32'hC8, rdv);
    rd(8'h40);
    chk("unmapped", 32'h0, rdv);
  endtask
  task automatic t_sw;
    wr(`AOWG_OFF_CONFIG, 32'h0);
    wr(`AOWG_OFF_SWDATA, 32'h1234ABCD);
    chk("sw", 32'h1234ABCD, {analog_out_one, analog_out_zero});
    chk("swload", 32'h1, dac_load);
    wr(`AOWG_OFF_CONFIG, 32'h1);
    n0 = n_loads;
    wr(`AOWG_OFF_SWDATA, 32'h0);
    idle(3);
    chk("swhw", n0, n_loads);
  endtask
  task automatic t_fin;
    wr(`AOWG_OFF_COUNT, 32'h3);
    wr(`AOWG_OFF_RATE, 32'h4);
    start_run(3);
    idle(1);
    chk("first", 32'h1, dac_load);
    idle(28);
    chk("fincnt", n0 + 3, n_loads);
    chk("fingap", 32'h4, last_gap);
    chk("finlast", 32'hA0025002, {analog_out_one, analog_out_zero});
    chk("finact", 32'h0, gen_active);
    rd(`AOWG_OFF_STATUS);
    chk("done", 32'h1, rdv[`AOWG_STS_DONE]);
  endtask
  task automatic t_under;
    wr(`AOWG_OFF_COUNT, 32'h4);
    wr(`AOWG_OFF_RATE, 32'h3);
    start_run(2);
    idle(30);
    chk("ufcnt", n0 + 2, n_loads);
    chk("ufhold", 32'hA0015001, {analog_out_one, analog_out_zero});
    rd(`AOWG_OFF_STATUS);
    chk("ufflag", 32'h1, rdv[`AOWG_STS_UNDERFLOW]);
    chk("ufact", 32'h1, gen_active);
    wr(`AOWG_OFF_CTRL, 32'h2);
    idle(3);
    chk("ufstop", 32'h0, gen_active);
  endtask
  task automatic t_cont;
    wr(`AOWG_OFF_CONFIG, 32'h3);
    wr(`AOWG_OFF_RATE, 32'h2);
    push(20);
    idle(60);
    chk("full", 32'h0, in_ready);
    rd(`AOWG_OFF_STATUS);
    chk("level", 32'h10, rdv[12:8]);
    u_host.gap = 3;
    n0 = n_loads;
    wr(`AOWG_OFF_CTRL, 32'h1);
    idle(150);
    chk("cntall", n0 + 20, n_loads);
    chk("cntact", 32'h1, gen_active);
    wr(`AOWG_OFF_CTRL, 32'h2);
    idle(3);
    chk("cntstop", 32'h0, gen_active);
    u_host.gap = 0;
  endtask
  task automatic t_trig;
    logic [1:0] v;
    logic [1:0] off;
    for (int i = 0; i < 4; i++)
    begin
      v = i[0] ? 2'b10 : 2'b01;
      off = {2{i[1]}};
      pin(~off);
      wr(`AOWG_OFF_COUNT, 32'h1);
      wr(`AOWG_OFF_CONFIG, 32'h5 | (i[0] << 3) | (i[1] << 4));
      start_run(1);
      pin(off);
      chk("wrongedge", n0, n_loads);
      pin(off ^ ~v);
      chk("otherpin", n0, n_loads);
      pin(off ^ v);
      chk("trigger", n0 + 1, n_loads);
      pin(off);
      pin(off ^ v);
      chk("retrig", n0 + 1, n_loads);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence after a five cycle reset
  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    trg = 2'b00;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    idle(1);
    t_reset();
    t_sw();
    t_fin();
    t_under();
    t_cont();
    t_trig();
    complete_run();
  end

  // cut a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule // aowg_ctrl_tb
